//--- core/can_bit_timing_pkg.sv
// constants, register layouts and types shared by the bit segment configuration block
// Function
// - with phase2_source_select set phase segment 2 uses phase2_length, otherwise the larger of phase 1 and the processing time.
// - with triple_sample_select set the bus line is sampled three times up to the sample point, otherwise once at it.
// - phase1_length code n gives a phase segment 1 of n plus one time quanta, 1 to 8.
// - propagation_length code n gives a propagation segment of n plus one time quanta, 1 to 8.
// - the bit timing registers are reachable only in configuration mode, and software enters that mode before changing them.
// - one time quantum lasts two times quantum_prescaler plus two clock periods.
// - phase2_length is ignored while phase2_source_select is clear.
package can_bit_timing_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte offsets on the plain register port
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 8;
    localparam logic [3:0]  OFS_CTL1     = 4'h0;   // quantum_prescaler
    localparam logic [3:0]  OFS_CTL2     = 4'h1;   // bit_timing_control_2
    localparam logic [3:0]  OFS_CTL3     = 4'h2;   // phase2_length
    localparam logic [3:0]  OFS_STATUS   = 4'h3;   // segment state, last bit

    // values after reset
    localparam logic [5:0]  PRESC_RESET  = 6'h00;
    localparam logic [7:0]  CTL2_RESET   = 8'h00;
    localparam logic [2:0]  PH2_RESET    = 3'h0;

    // field sizes and timing
    localparam int          PRESC_W      = 6;
    localparam int          SEG_W        = 3;
    localparam logic [3:0]  IPT_TQ       = 4'h2;   // processing time in quanta

    ////////////////////////////////////////////////////////////////////////////
    // bit 7 source select, bit 6 triple, bits 5:3 phase 1, bits 2:0 propagation
    typedef struct packed
    {
        logic               phase2_source_select;
        logic               triple_sample_select;
        logic [SEG_W-1:0]   phase1_length;
        logic [SEG_W-1:0]   propagation_length;
    } ctl2_t;

    typedef struct packed
    {
        logic [3:0]         zero;
        logic               rx_bit;
        logic [1:0]         segment;
        logic               running;
    } status_t;

    typedef struct packed
    {
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
        logic               wr;
        logic               rd;
    } reg_req_t;

    typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} seg_t;

endpackage

//--- core/quantum_divider.sv
// time quantum enable divider from the reference clock
`timescale 1ns/1ns
module quantum_divider
    import can_bit_timing_pkg::*;
#(
    parameter int W = PRESC_W
)
(
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic         run_i,
    input  wire logic [W-1:0] presc_i,
    output logic              tick_o
);

    generate
        if (W < 1 || W > 8)
        begin : g_bad_width
            $error("quantum_divider width out of range");
        end
    endgenerate

    logic [W:0] cnt_ff;
    logic       tick_ff;
    logic [W:0] last;

    // period is 2*(presc+1) clocks: last count is 2*presc+1
    assign last = {presc_i, 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // held at zero while stopped so the first quantum is full length
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end
        else if (!run_i)
        begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end
        else if (cnt_ff == last)
        begin
            cnt_ff  <= '0;
            tick_ff <= 1'b1;
        end
        else
        begin
            cnt_ff  <= cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    assign tick_o = tick_ff;

endmodule

//--- core/can_bit_segment_config.sv
// bit segment configuration register and the bit timing sequencer it steers
`timescale 1ns/1ns
module can_bit_segment_config
    import can_bit_timing_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire reg_req_t          reg_req_i,
    input  wire logic              config_mode_i,
    input  wire logic              bus_rx_i,
    output logic [DATA_W-1:0]      rd_data_o,
    output logic                   sample_o,
    output logic                   rx_bit_o
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [PRESC_W-1:0] presc_ff;
    ctl2_t              ctl2_ff;
    logic [SEG_W-1:0]   ph2_ff;
    seg_t               seg_ff;
    seg_t               nxt_seg;
    logic [3:0]         q_cnt_ff;
    logic [3:0]         seg_last;
    logic [3:0]         ph2_last;
    logic [3:0]         auto_last;
    logic [1:0]         hist_ff;
    logic               tq_tick;
    logic               running;
    logic               seg_end;
    logic               sample_pt;
    logic               sample_ff;
    logic               rx_bit_ff;
    logic [DATA_W-1:0]  rd_data_ff;
    logic [DATA_W-1:0]  nxt_rd_data;
    status_t            status;

    // timing runs only outside configuration mode
    assign running = !config_mode_i;

    ////////////////////////////////////////////////////////////////////////////
    // decoding for the read path and the majority vote of the triple sample
    function automatic logic is_cfg_reg(input logic [ADDR_W-1:0] a);
        is_cfg_reg = (a == OFS_CTL1) || (a == OFS_CTL2) || (a == OFS_CTL3);
    endfunction

    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register writes, dropped outside configuration mode so that timing
    // cannot shift under a frame in progress
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            presc_ff <= PRESC_RESET;
        end
        else if (reg_req_i.wr && config_mode_i && reg_req_i.addr == OFS_CTL1)
        begin
            presc_ff <= reg_req_i.wdata[PRESC_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctl2_ff <= ctl2_t'(CTL2_RESET);
        end
        else if (reg_req_i.wr && config_mode_i && reg_req_i.addr == OFS_CTL2)
        begin
            ctl2_ff <= ctl2_t'(reg_req_i.wdata);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ph2_ff <= PH2_RESET;
        end
        else if (reg_req_i.wr && config_mode_i && reg_req_i.addr == OFS_CTL3)
        begin
            ph2_ff <= reg_req_i.wdata[SEG_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path: config registers read zero outside configuration mode
    assign status = '{zero: 4'h0, rx_bit: rx_bit_ff, segment: seg_ff, running: running};

    always_comb
    begin
        nxt_rd_data = '0;
        if (reg_req_i.rd)
        begin
            if (is_cfg_reg(reg_req_i.addr) && !config_mode_i)
                nxt_rd_data = '0;
            else if (reg_req_i.addr == OFS_CTL1)
                nxt_rd_data = {2'h0, presc_ff};
            else if (reg_req_i.addr == OFS_CTL2)
                nxt_rd_data = ctl2_ff;
            else if (reg_req_i.addr == OFS_CTL3)
                nxt_rd_data = {5'h00, ph2_ff};
            else if (reg_req_i.addr == OFS_STATUS)
                nxt_rd_data = status;
            else
                nxt_rd_data = '0;
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rd_data_ff <= '0;
        else
            rd_data_ff <= nxt_rd_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // time quantum enable
    quantum_divider #(.W(PRESC_W)) u_quantum_divider
    (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .run_i     (running),
        .presc_i   (presc_ff),
        .tick_o    (tq_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // segment lengths minus one; phase 2 length field is not even looked at
    // in automatic mode
    assign auto_last = ({1'b0, ctl2_ff.phase1_length} + 4'h1 > IPT_TQ) ?
                       {1'b0, ctl2_ff.phase1_length} : IPT_TQ - 4'h1;
    assign ph2_last  = ctl2_ff.phase2_source_select ? {1'b0, ph2_ff} : auto_last;

    always_comb
    begin
        case (seg_ff)
            SEG_SYNC: seg_last = 4'h0;
            SEG_PROP: seg_last = {1'b0, ctl2_ff.propagation_length};
            SEG_PH1:  seg_last = {1'b0, ctl2_ff.phase1_length};
            SEG_PH2:  seg_last = ph2_last;
            default:  seg_last = 4'h0;
        endcase
    end

    assign seg_end   = tq_tick && (q_cnt_ff == seg_last);
    assign sample_pt = seg_end && (seg_ff == SEG_PH1);

    always_comb
    begin
        case (seg_ff)
            SEG_SYNC: nxt_seg = SEG_PROP;
            SEG_PROP: nxt_seg = SEG_PH1;
            SEG_PH1:  nxt_seg = SEG_PH2;
            SEG_PH2:  nxt_seg = SEG_SYNC;
            default:  nxt_seg = SEG_SYNC;
        endcase
    end

    // segment sequencer, parked in sync while configuring
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            seg_ff   <= SEG_SYNC;
            q_cnt_ff <= 4'h0;
        end
        else if (!running)
        begin
            seg_ff   <= SEG_SYNC;
            q_cnt_ff <= 4'h0;
        end
        else if (seg_end)
        begin
            seg_ff   <= nxt_seg;
            q_cnt_ff <= 4'h0;
        end
        else if (tq_tick)
        begin
            q_cnt_ff <= q_cnt_ff + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus line history at quantum edges for the triple sample; majority
    // voting filters a single glitchy quantum without delaying the sample point or the result
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            hist_ff <= 2'h3;
        else if (tq_tick)
            hist_ff <= {hist_ff[0], bus_rx_i};
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sample_ff <= 1'b0;
            rx_bit_ff <= 1'b1; // recessive
        end
        else
        begin
            sample_ff <= sample_pt;
            if (sample_pt)
                rx_bit_ff <= ctl2_ff.triple_sample_select ?
                             majority({hist_ff, bus_rx_i}) : bus_rx_i;
        end
    end

    assign rd_data_o = rd_data_ff;
    assign sample_o  = sample_ff;
    assign rx_bit_o  = rx_bit_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    logic [PRESC_W:0] gap_ff;
    logic             gap_ok_ff;

    // cycles since the previous quantum tick
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            gap_ff    <= '0;
            gap_ok_ff <= 1'b0;
        end
        else if (!running)
        begin
            gap_ff    <= '0;
            gap_ok_ff <= 1'b0;
        end
        else if (tq_tick)
        begin
            gap_ff    <= '0;
            gap_ok_ff <= 1'b1;
        end
        else
        begin
            gap_ff <= gap_ff + 1'b1;
        end
    end

    sequence s_cfg_write;
        reg_req_i.wr && !config_mode_i && reg_req_i.addr == OFS_CTL2;
    endsequence

    chk_ph2_free_end: assert property (
        running && tq_tick && seg_ff == SEG_PH2 && ctl2_ff.phase2_source_select
        && q_cnt_ff == {1'b0, ph2_ff} && !config_mode_i |=> seg_ff == SEG_SYNC)
        else $error("phase 2 did not end at programmed length");

    chk_triple_vote: assert property (
        sample_pt |=> rx_bit_o == ($past(ctl2_ff.triple_sample_select) ?
            majority({$past(hist_ff), $past(bus_rx_i)}) : $past(bus_rx_i)) ##0 sample_o)
        else $error("sampled bit wrong for sampling mode");

    chk_phase1_len: assert property (
        tq_tick && !config_mode_i && seg_ff == SEG_PH1
        && q_cnt_ff < {1'b0, ctl2_ff.phase1_length} |=> seg_ff == SEG_PH1)
        else $error("phase 1 ended early");

    chk_prop_len: assert property (
        tq_tick && !config_mode_i && seg_ff == SEG_PROP
        && q_cnt_ff == {1'b0, ctl2_ff.propagation_length} |=> seg_ff == SEG_PH1)
        else $error("propagation segment wrong length");

    chk_read_locked: assert property (
        reg_req_i.rd && !config_mode_i && reg_req_i.addr == OFS_CTL2 |=> rd_data_o == 8'h00)
        else $error("config register readable outside configuration mode");

    chk_quantum_gap: assert property (
        tq_tick && gap_ok_ff |-> gap_ff == {presc_ff, 1'b1})
        else $error("time quantum length wrong");

    chk_ph2_ignored: assert property (
        tq_tick && !config_mode_i && seg_ff == SEG_PH2 && !ctl2_ff.phase2_source_select
        && q_cnt_ff == (({1'b0, ctl2_ff.phase1_length} >= IPT_TQ) ?
           {1'b0, ctl2_ff.phase1_length} : IPT_TQ - 4'h1) |=> seg_ff == SEG_SYNC)
        else $error("automatic phase 2 length wrong");

    chk_write_locked: assert property (
        s_cfg_write |=> $stable(ctl2_ff))
        else $error("register changed outside configuration mode");

    // a blocked write must not leak into the neighbouring timing registers either
    chk_other_locked: assert property (
        reg_req_i.wr && !config_mode_i |=> $stable(presc_ff) && $stable(ph2_ff))
        else $error("timing register changed outside configuration mode");

    // last quantum of phase 1 is the sample point, so segment and pulse move together
    sequence s_ph1_last;
        tq_tick && !config_mode_i && seg_ff == SEG_PH1 && q_cnt_ff == {1'b0, ctl2_ff.phase1_length};
    endsequence

    chk_phase1_end: assert property (
        s_ph1_last |=> seg_ff == SEG_PH2 && sample_o)
        else $error("phase 1 did not end at programmed length");

    // an early exit would shorten the bit without moving the sample point check
    chk_prop_early: assert property (
        tq_tick && !config_mode_i && seg_ff == SEG_PROP
        && q_cnt_ff < {1'b0, ctl2_ff.propagation_length} |=> seg_ff == SEG_PROP)
        else $error("propagation segment ended early");

endmodule

//--- sim/can_bus_line_model.sv
// bus line model: receive level with an optional short dominant flip around the sample point
`timescale 1ns/1ns
module can_bus_line_model
#(
    parameter int PERIOD = 10
)
(
    input  wire logic  ref_clk_i,
    input  wire logic  rst_i,
    input  wire logic  sample_i,
    input  wire logic  level_i,
    input  wire logic  glitch_i,
    output logic       bus_o
);
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [15:0] LO = 16'(PERIOD - 3);
    localparam logic [15:0] HI = 16'(PERIOD - 1);
    logic [15:0] cnt_ff;

    // cycles since the last sample pulse; saturates so no flip happens before the first one
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_ff <= 16'hFFFF;
        else if (sample_i)
            cnt_ff <= 16'h0001;
        else if (cnt_ff != 16'hFFFF)
            cnt_ff <= cnt_ff + 16'h0001;
    end

    // three clocks wide so that exactly one quantum tick (two clocks apart) sees the flip
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            bus_o <= 1'b1;
        else
            bus_o <= level_i ^ (glitch_i && cnt_ff >= LO && cnt_ff <= HI);
    end
endmodule

//--- sim/tb.sv
// self-checking bench for the bit segment configuration block
`timescale 1ns/1ns
module tb;
    import can_bit_timing_pkg::*;
    typedef struct packed
    {
        logic [5:0]  presc;
        logic [7:0]  ctl2;
        logic [2:0]  ph2;
        logic [15:0] period;
    } row_t;
    ////////////////////////////////////////////////////////////////////////////
    logic        ref_clk_i     = 1'b0;
    logic        rst_i         = 1'b1;
    logic        config_mode_i = 1'b1;
    logic        level         = 1'b1;
    logic        glitch        = 1'b0;
    reg_req_t    reg_req       = '0;
    logic        bus_rx;
    logic        sample;
    logic        rx_bit;
    logic [7:0]  rd_data;
    int          n_errors      = 0;
    int          cmp_count     = 0;
    // bit period in clocks = (sync + prop + ph1 + ph2) quanta times 2*(presc+1)
    row_t        rows [7]      = '{'{6'h00, 8'h00, 3'h0, 16'h000A}, '{6'h01, 8'h3F, 3'h0, 16'h0064},
                                   '{6'h00, 8'h80, 3'h7, 16'h0016}, '{6'h02, 8'h93, 3'h0, 16'h0036},
                                   '{6'h00, 8'h08, 3'h5, 16'h000C}, '{6'h00, 8'h40, 3'h0, 16'h000A},
                                   '{6'h3F, 8'h00, 3'h0, 16'h0280}};

    always #5 ref_clk_i = ~ref_clk_i;

    can_bit_segment_config can_bit_segment_config_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .reg_req_i(reg_req), .config_mode_i(config_mode_i), .bus_rx_i(bus_rx), .rd_data_o(rd_data),
        .sample_o(sample), .rx_bit_o(rx_bit));
    can_bus_line_model #(.PERIOD(10)) can_bus_line_model_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .sample_i(sample), .level_i(level), .glitch_i(glitch), .bus_o(bus_rx));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            $display("wrong value at %0t: %s", $time, msg);
            n_errors++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        reg_req.wr    <= 1'b1;
        @(posedge ref_clk_i);
        reg_req.wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string msg);
        @(posedge ref_clk_i);
        reg_req.addr <= a;
        reg_req.rd   <= 1'b1;
        @(posedge ref_clk_i);
        reg_req.rd   <= 1'b0;
        #1 check(rd_data === e, msg);
    endtask

    // bounded wait for the next sample pulse, n = clocks waited
    task automatic wait_sample(output int n);
        n = 0;
        do
        begin
            @(posedge ref_clk_i);
            #1 n++;
        end while (sample !== 1'b1 && n < 1000);
        if (n >= 1000)
            check(1'b0, "no sample pulse");
    endtask

    // software enters configuration mode before touching the timing fields
    task automatic run_row(input row_t r);
        int n;
        @(posedge ref_clk_i);
        config_mode_i <= 1'b1;
        wr(OFS_CTL1, {2'h0, r.presc});
        wr(OFS_CTL2, r.ctl2);
        wr(OFS_CTL3, {5'h0, r.ph2});
        rd(OFS_CTL2, r.ctl2, "config readback");
        @(posedge ref_clk_i);
        config_mode_i <= 1'b0;
        wait_sample(n);
        wait_sample(n);
        check(16'(n) === r.period, "bit period");
    endtask

    task automatic stop_test;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few thousand clocks the sequence needs
    initial
    begin
        #300000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        int n;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1 check(rx_bit === 1'b1 && sample === 1'b0 && rd_data === 8'h00, "reset outputs");
        rd(OFS_CTL2, CTL2_RESET, "ctl2 reset value");
        rd(OFS_CTL1, 8'h00, "presc reset value");
        rd(OFS_CTL3, 8'h00, "ph2 reset value");
        rd(OFS_STATUS, 8'h08, "status after reset");
        wr(OFS_CTL2, 8'hA5);
        rd(OFS_CTL2, 8'hA5, "ctl2 write in config mode");
        @(posedge ref_clk_i);
        config_mode_i <= 1'b0;
        wr(OFS_CTL2, 8'h5A);
        wr(OFS_CTL1, 8'h3F);
        rd(OFS_CTL2, 8'h00, "ctl2 read outside config mode");
        @(posedge ref_clk_i);
        config_mode_i <= 1'b1;
        rd(OFS_CTL2, 8'hA5, "ctl2 kept after blocked write");
        rd(OFS_CTL1, 8'h00, "presc kept after blocked write");
        rd(4'hF, 8'h00, "unmapped read");
        foreach (rows[i])
            run_row(rows[i]);
        // a flip at the sample tick alone wins with one sample, loses the vote with three
        glitch <= 1'b1;
        run_row(rows[0]);
        repeat (3) wait_sample(n);
        check(rx_bit === 1'b0, "single sample sees flip");
        run_row(rows[5]);
        repeat (3) wait_sample(n);
        check(rx_bit === 1'b1, "triple sample outvotes flip");
        glitch <= 1'b0;
        level  <= 1'b0;
        repeat (3) wait_sample(n);
        check(rx_bit === 1'b0, "triple sample dominant level");
        // second reset in mid-run
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        @(posedge ref_clk_i);
        #1 check(rx_bit === 1'b1 && sample === 1'b0, "mid-run reset outputs");
        @(posedge ref_clk_i);
        config_mode_i <= 1'b1;
        rst_i <= 1'b0;
        rd(OFS_CTL2, CTL2_RESET, "ctl2 after second reset");
        stop_test();
    end
endmodule
